// *** rtl/uart_block_pkg.sv ***
// Constants, types and register map for one two-channel serial block
// How it works
// - Each channel's aux_input_one level is always readable in input change and pin registers.
// - Aux control bit 5 clear selects aux_input_one as the timer's external clock.
// - Only the first channel's aux_input_one can clock the block's single timer.
// - A change detector records every transition of aux_input_one.
// - Output config bit 7 sets both bidirectional pins: 0 input, 1 output.
// - The input pin register always shows both bidirectional pin levels.
// - First pin as input is the transmit external clock, 1x or 16x by clock select.
// - First pin as output carries the channel's transmit-holding-empty status.
// - Second pin as input is the receive external clock, 1x or 16x by clock select.
// - Second pin as output carries the interrupt-status receive-ready or FIFO-full bit.
// - One interrupt output per block, from ready, break change, terminal count, input change.
// - The interrupt output only asserts for conditions enabled in the mask register.
// - Reading interrupt status returns all active conditions, unmasked.
// - Status driven onto the bidirectional pins ignores the interrupt mask.
// - Reset and the reset-pointer command point the mode pointer at the first mode register.
// - Any mode read, or mode write with byte lane 0 selected, while at the first register moves the pointer to the second.
// - Each block holds a programmable 16-bit counter/timer.
// - Blocks are independent; each holds two channels that behave alike, except that only the first one's aux_input_one clocks the timer.
// - The block's base clock times all internal logic, and the counter/timer while aux control bit 5 is set.
package uart_block_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_INPUT_CHANGE_REG_ACR    = 4'h4;
  localparam logic [3:0] IDX_ISR_IMR     = 4'h5;
  localparam logic [3:0] IDX_CT_UPPER    = 4'h6;
  localparam logic [3:0] IDX_CT_LOWER    = 4'h7;
  localparam logic [3:0] IDX_IPR_OUTPUT_CONFIG_REG    = 4'hd;
  localparam logic [3:0] IDX_TIMER_START = 4'he;
  localparam logic [3:0] IDX_TIMER_STOP  = 4'hf;
  // Per-channel registers: index bit 3 picks the channel, bit 2 clear
  localparam logic [1:0] CH_MODE         = 2'h0;
  localparam logic [1:0] CH_STAT_CSR     = 2'h1;
  localparam logic [1:0] CH_CMD          = 2'h2;

  localparam logic [3:0] CMD_RESET_PTR   = 4'h1;
  localparam logic [3:0] CMD_RESET_BREAK = 4'h5;
  localparam logic [3:0] CSR_EXT_16X     = 4'he;
  localparam logic [3:0] CSR_EXT_1X      = 4'hf;

  localparam int ACR_TIMER_INT_BIT = 5;
  localparam int OUTPUT_CONFIG_REG_PIN_OUT_BIT  = 7;
  localparam int ISR_TX_A          = 0;
  localparam int ISR_RX_A          = 1;
  localparam int ISR_BRK_A         = 2;
  localparam int ISR_TIMER         = 3;
  localparam int ISR_TX_B          = 4;
  localparam int ISR_RX_B          = 5;
  localparam int ISR_BRK_B         = 6;
  localparam int ISR_IN_CHANGE     = 7;

  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  typedef enum logic {PTR_FIRST, PTR_SECOND} mode_ptr_t;

  // Status that a channel's serial section hands to the block
  typedef struct packed {
    logic txEmpty;
    logic rxReadyFull;
    logic breakChange;
  } chan_status_t;

endpackage

// *** rtl/dual_channel_block.sv ***
// One two-channel block: bus slave, interrupt, mode pointer, timer and pin control
`timescale 1ns/1ps
module dual_channel_block import uart_block_pkg::*; #(
  parameter int TIMER_W = 16
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         adr_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  input  wire logic               we_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  output logic                    ack_o,
  input  wire chan_status_t [1:0] chanStatus,
  input  wire logic [1:0]         auxInputOne,
  input  wire logic [1:0]         bidirPinOneIn,
  output logic      [1:0]         bidirPinOneOut,
  output logic      [1:0]         bidirPinOneOe,
  input  wire logic [1:0]         bidirPinTwoIn,
  output logic      [1:0]         bidirPinTwoOut,
  output logic      [1:0]         bidirPinTwoOe,
  output logic      [1:0]         txExtClock,
  output logic      [1:0]         txExtSelect,
  output logic      [1:0]         txExt16x,
  output logic      [1:0]         rxExtClock,
  output logic      [1:0]         rxExtSelect,
  output logic      [1:0]         rxExt16x,
  output logic                    timerExtClock,
  output logic                    timerTerminal,
  output logic                    blockIrqN
);

  logic               access;
  logic               wrEn;
  logic               rdEn;
  logic [3:0]         idx;
  logic               chanReg;
  logic [7:0]         readMux;
  logic [7:0]         irq_status_reg;
  logic [7:0]         aux_control_reg;
  logic [7:0]         irq_mask_reg;
  logic [7:0]         output_config_reg;
  logic [7:0]         clock_select_reg [2];
  logic [7:0]         modeFirst [2];
  logic [7:0]         modeSecond [2];
  mode_ptr_t          modePtr [2];
  logic [1:0]         breakFlag;
  logic [1:0]         inChange;
  logic [1:0]         auxMeta;
  logic [1:0]         auxLevel;
  logic [1:0]         auxPrev;
  logic [1:0]         p1Meta;
  logic [1:0]         p1Level;
  logic [1:0]         p2Meta;
  logic [1:0]         p2Level;
  logic [TIMER_W-1:0] preset;
  logic [TIMER_W-1:0] count;
  logic               running;
  logic               tcFlag;
  logic               timerTick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Bus decode: one request is taken while ack is low, answered next edge
  assign access  = cyc_i & stb_i & ~ack_o;
  assign wrEn    = access & we_i & sel_i[0];
  assign rdEn    = access & ~we_i;
  assign idx     = adr_i[5:2];
  assign chanReg = ~idx[2];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dat_o <= 32'h00000000;
    end else if (rdEn) begin
      dat_o <= {24'h000000, readMux};
    end else begin
      dat_o <= 32'h00000000;
    end
  end

  a_ack_answers: assert property (access |=> ack_o ##1 !ack_o)
    else $error("bus request not answered in one cycle");

  // Channel-scoped and block-scoped registers share one index space
  always_comb begin
    readMux = 8'h00;
    if (chanReg) begin
      unique case (idx[1:0])
        CH_MODE: readMux = (modePtr[idx[3]] == PTR_FIRST) ? modeFirst[idx[3]]
                                                          : modeSecond[idx[3]];
        CH_STAT_CSR: readMux = {5'h00, chanStatus[idx[3]].txEmpty, 1'b0,
                                chanStatus[idx[3]].rxReadyFull};
        default: readMux = 8'h00;
      endcase
    end else begin
      unique case (idx)
        IDX_INPUT_CHANGE_REG_ACR: readMux = {inChange[1], 1'b0, inChange[0], 1'b0,
                                 auxLevel[1], 1'b0, auxLevel[0], 1'b0};
        IDX_ISR_IMR:  readMux = irq_status_reg;
        IDX_CT_UPPER: readMux = count[TIMER_W-1 -: 8];
        IDX_CT_LOWER: readMux = count[7:0];
        IDX_IPR_OUTPUT_CONFIG_REG: readMux = {p2Level[1], p1Level[1], p2Level[0], p1Level[0],
                                 auxLevel[1], 1'b0, auxLevel[0], 1'b0};
        default:      readMux = 8'h00;
      endcase
    end
  end

  // Both channels are built from the same logic
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic hit;
    assign hit = access & chanReg & (idx[3] == 1'(c));

    // Pin levels come from outside: two flops before any use
    always_ff @(posedge clk) begin
      auxMeta[c] <= auxInputOne[c];
      auxLevel[c] <= auxMeta[c];
      auxPrev[c] <= auxLevel[c];
      p1Meta[c] <= bidirPinOneIn[c];
      p1Level[c] <= p1Meta[c];
      p2Meta[c] <= bidirPinTwoIn[c];
      p2Level[c] <= p2Meta[c];
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        modePtr[c] <= PTR_FIRST;
        modeFirst[c] <= REG_RESET;
        modeSecond[c] <= REG_RESET;
      end else if (hit && idx[1:0] == CH_MODE) begin
        if (wrEn && modePtr[c] == PTR_FIRST) begin
          modeFirst[c] <= dat_i[7:0];
        end else if (wrEn) begin
          modeSecond[c] <= dat_i[7:0];
        end
        if (we_i == 1'b0 || sel_i[0]) begin
          modePtr[c] <= PTR_SECOND;
        end
      end else if (hit && wrEn && idx[1:0] == CH_CMD
                   && dat_i[7:4] == CMD_RESET_PTR) begin
        modePtr[c] <= PTR_FIRST;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        clock_select_reg[c] <= REG_RESET;
      end else if (hit && wrEn && idx[1:0] == CH_STAT_CSR) begin
        clock_select_reg[c] <= dat_i[7:0];
      end
    end

    // Sticky flags: a new event in the clearing cycle wins
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        breakFlag[c] <= 1'b0;
      end else if (chanStatus[c].breakChange) begin
        breakFlag[c] <= 1'b1;
      end else if (hit && wrEn && idx[1:0] == CH_CMD
                   && dat_i[7:4] == CMD_RESET_BREAK) begin
        breakFlag[c] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        inChange[c] <= 1'b0;
      end else if (auxLevel[c] != auxPrev[c]) begin
        inChange[c] <= 1'b1;
      end else if (rdEn && idx == IDX_INPUT_CHANGE_REG_ACR) begin
        inChange[c] <= 1'b0;
      end
    end

    // Pins: one direction bit serves both pins of both channels
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        bidirPinOneOe[c] <= 1'b0;
        bidirPinTwoOe[c] <= 1'b0;
        bidirPinOneOut[c] <= 1'b0;
        bidirPinTwoOut[c] <= 1'b0;
      end else begin
        bidirPinOneOe[c] <= output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT];
        bidirPinTwoOe[c] <= output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT];
        bidirPinOneOut[c] <= chanStatus[c].txEmpty;
        bidirPinTwoOut[c] <= irq_status_reg[c == 0 ? ISR_RX_A : ISR_RX_B];
      end
    end

    // External serial clocks only while the pin is an input
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        txExtClock[c] <= 1'b0;
        txExtSelect[c] <= 1'b0;
        txExt16x[c] <= 1'b0;
        rxExtClock[c] <= 1'b0;
        rxExtSelect[c] <= 1'b0;
        rxExt16x[c] <= 1'b0;
      end else begin
        txExtClock[c] <= p1Level[c] & ~output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT];
        txExtSelect[c] <= ~output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT]
                          & (clock_select_reg[c][3:0] == CSR_EXT_1X || clock_select_reg[c][3:0] == CSR_EXT_16X);
        txExt16x[c] <= (clock_select_reg[c][3:0] == CSR_EXT_16X);
        rxExtClock[c] <= p2Level[c] & ~output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT];
        rxExtSelect[c] <= ~output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT]
                          & (clock_select_reg[c][7:4] == CSR_EXT_1X || clock_select_reg[c][7:4] == CSR_EXT_16X);
        rxExt16x[c] <= (clock_select_reg[c][7:4] == CSR_EXT_16X);
      end
    end
  end

  // Block-wide control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_control_reg <= REG_RESET;
      irq_mask_reg <= REG_RESET;
      output_config_reg <= REG_RESET;
    end else if (wrEn && !chanReg) begin
      if (idx == IDX_INPUT_CHANGE_REG_ACR) begin
        aux_control_reg <= dat_i[7:0];
      end
      if (idx == IDX_ISR_IMR) begin
        irq_mask_reg <= dat_i[7:0];
      end
      if (idx == IDX_IPR_OUTPUT_CONFIG_REG) begin
        output_config_reg <= dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preset <= COUNT_RESET;
    end else if (wrEn && idx == IDX_CT_UPPER) begin
      preset[TIMER_W-1 -: 8] <= dat_i[7:0];
    end else if (wrEn && idx == IDX_CT_LOWER) begin
      preset[7:0] <= dat_i[7:0];
    end
  end

  // Timer clock: first channel's aux input rising edge, else the block clock.
  // The edge is seen after synchronising, so the pin must stay below clk/4.
  assign timerTick = aux_control_reg[ACR_TIMER_INT_BIT] ? 1'b1
                   : (auxLevel[0] & ~auxPrev[0]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      running <= 1'b0;
      count <= COUNT_RESET;
    end else if (rdEn && idx == IDX_TIMER_START) begin
      running <= 1'b1;
      count <= preset;
    end else if (rdEn && idx == IDX_TIMER_STOP) begin
      running <= 1'b0;
    end else if (running && timerTick) begin
      count <= (count == '0) ? preset : count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tcFlag <= 1'b0;
    end else if (running && timerTick && count == '0) begin
      tcFlag <= 1'b1;
    end else if (rdEn && idx == IDX_TIMER_STOP) begin
      tcFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timerExtClock <= 1'b0;
      timerTerminal <= 1'b0;
    end else begin
      timerExtClock <= auxLevel[0] & ~aux_control_reg[ACR_TIMER_INT_BIT];
      timerTerminal <= tcFlag;
    end
  end

  // Status is never masked; only the interrupt output is
  assign irq_status_reg = {|inChange, breakFlag[1], chanStatus[1].rxReadyFull, chanStatus[1].txEmpty,
                tcFlag, breakFlag[0], chanStatus[0].rxReadyFull,
                chanStatus[0].txEmpty};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blockIrqN <= 1'b1;
    end else begin
      blockIrqN <= ~|(irq_status_reg & irq_mask_reg);
    end
  end

  sequence firstModeAccessA;
    access && chanReg && !idx[3] && idx[1:0] == CH_MODE && modePtr[0] == PTR_FIRST
      && (!we_i || sel_i[0]);
  endsequence

  sequence ptrResetCmdA;
    wrEn && chanReg && !idx[3] && idx[1:0] == CH_CMD && dat_i[7:4] == CMD_RESET_PTR;
  endsequence

  a_ptr_advances: assert property (firstModeAccessA |=> modePtr[0] == PTR_SECOND
                                   ##1 modePtr[0] == PTR_SECOND [*2])
    else $error("mode pointer did not move to second register");
  a_ptr_resets: assert property (ptrResetCmdA |=> modePtr[0] == PTR_FIRST)
    else $error("reset-pointer command ignored");
  a_irq_masked: assert property ((irq_status_reg & irq_mask_reg) == 8'h00 |=> blockIrqN)
    else $error("interrupt asserted with nothing enabled");
  a_irq_raised: assert property ((irq_status_reg & irq_mask_reg) != 8'h00 |=> !blockIrqN)
    else $error("enabled condition did not assert interrupt");
  a_isr_unmasked: assert property (rdEn && idx == IDX_ISR_IMR
                                   |=> dat_o[7:0] == $past(irq_status_reg))
    else $error("status read differs from active conditions");
  a_aux_level_read: assert property (rdEn && idx == IDX_IPR_OUTPUT_CONFIG_REG
                                     |=> dat_o[1] == $past(auxLevel[0]))
    else $error("aux input level not reported");
  a_change_caught: assert property (auxLevel[0] != auxPrev[0] |=> inChange[0])
    else $error("aux input transition lost");
  a_pin_direction: assert property (output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT]
                                    |=> &bidirPinOneOe && &bidirPinTwoOe)
    else $error("bidirectional pins not driven in output mode");
  a_pin_rx_status: assert property (output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT] && irq_status_reg[ISR_RX_A] && irq_mask_reg == 8'h00
                                    |=> bidirPinTwoOut[0])
    else $error("receive status missing on second pin");
  a_tx_ext_clock: assert property (!output_config_reg[OUTPUT_CONFIG_REG_PIN_OUT_BIT]
                                   |=> txExtClock == $past(p1Level))
    else $error("transmit clock does not follow first pin");
  a_timer_holds: assert property (!aux_control_reg[ACR_TIMER_INT_BIT] && running && !rdEn
                                  && auxLevel[0] == auxPrev[0]
                                  |=> count == $past(count))
    else $error("timer counted without an external edge");

endmodule

// *** tb/pin_env.sv ***
// Far side of a bidirectional pin pair: pull-up plus an optional outside driver
`timescale 1ns/1ps
module pin_env (
  input  wire logic [1:0] devOut,
  input  wire logic [1:0] devOe,
  input  wire logic [1:0] farVal,
  input  wire logic [1:0] farOe,
  output logic      [1:0] level
);
  // An undriven pin floats up, so a stale value can never pass for a read
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      level[i] = devOe[i] ? devOut[i] : (farOe[i] ? farVal[i] : 1'b1);
    end
  end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for one two-channel serial block
`timescale 1ns/1ps
module tb import uart_block_pkg::*; ;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic         [7:0] adr = 8'h00;
  logic        [31:0] datI = 32'h0;
  logic        [31:0] datO;
  logic               we = 1'b0;
  logic         [3:0] sel = 4'h0;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               ack;
  chan_status_t [1:0] chanStatus = '0;
  logic         [1:0] auxInputOne = 2'b00;
  logic         [1:0] oneOut, oneOe, twoOut, twoOe, oneLvl, twoLvl;
  logic         [1:0] extOne = 2'b00, extTwo = 2'b00, extOe = 2'b00;
  logic         [1:0] tx_ext_clock, txSel, tx16, rx_ext_clock, rxSel, rx16;
  logic               timerClk, timerEnd, irqN;
  logic         [7:0] rdVal;
  int                 n_fail = 0, checks_done = 0, cycles = 0;

  always #10 clk = ~clk;

  dual_channel_block #(.TIMER_W(16)) dual_channel_block_inst (
    .clk(clk), .rst_n(rst_n), .adr_i(adr), .dat_i(datI), .dat_o(datO), .we_i(we),
    .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .chanStatus(chanStatus),
    .auxInputOne(auxInputOne), .bidirPinOneIn(oneLvl), .bidirPinOneOut(oneOut),
    .bidirPinOneOe(oneOe), .bidirPinTwoIn(twoLvl), .bidirPinTwoOut(twoOut),
    .bidirPinTwoOe(twoOe), .txExtClock(tx_ext_clock), .txExtSelect(txSel), .txExt16x(tx16),
    .rxExtClock(rx_ext_clock), .rxExtSelect(rxSel), .rxExt16x(rx16), .timerExtClock(timerClk),
    .timerTerminal(timerEnd), .blockIrqN(irqN)
  );
  pin_env pinOneEnv (.devOut(oneOut), .devOe(oneOe), .farVal(extOne), .farOe(extOe),
                     .level(oneLvl));
  pin_env pinTwoEnv (.devOut(twoOut), .devOe(twoOe), .farVal(extTwo), .farOe(extOe),
                     .level(twoLvl));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; ack is sampled as the edge saw it, before its own update
  task automatic bus(input logic [3:0] idx, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'b00, idx, 2'b00};
    datI <= {24'h0, d};
    sel  <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rdVal = datO[7:0];
    if (n >= 40) begin
      chk("bus ack", 8'h00, 8'h01);
      give_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input string what);
    bus(idx, 1'b0, 8'h00);
    chk(what, rdVal, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    int i;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wt(2);
    chk("irq idle", {7'h0, irqN}, 8'h01);
    chk("oe idle", {4'h0, oneOe, twoOe}, 8'h00);
    rd(4'h5, 8'h00, "isr reset");
    rd(4'hd, 8'hf0, "pins reset");
    $display("test reset finished");
    wr(4'h0, 8'h11);
    wr(4'h0, 8'h22);
    rd(4'h0, 8'h22, "mode second");
    wr(4'h2, {CMD_RESET_BREAK, 4'h0});
    rd(4'h0, 8'h22, "mode kept");
    wr(4'h2, {CMD_RESET_PTR, 4'h0});
    rd(4'h0, 8'h11, "mode first");
    rd(4'h0, 8'h22, "mode next");
    rd(4'h8, 8'h00, "mode b first");
    wr(4'h8, 8'h33);
    wr(4'ha, {CMD_RESET_PTR, 4'h0});
    rd(4'h8, 8'h00, "mode b again");
    rd(4'h8, 8'h33, "mode b second");
    $display("test mode pointer finished");
    @(posedge clk) chanStatus[0].txEmpty <= 1'b1;
    rd(4'h5, 8'h01, "isr tx a");
    wt(3);
    chk("irq masked", {7'h0, irqN}, 8'h01);
    wr(4'h5, 8'h01);
    wt(3);
    chk("irq tx a", {7'h0, irqN}, 8'h00);
    @(posedge clk) chanStatus[1].rxReadyFull <= 1'b1;
    wr(4'h5, 8'h20);
    @(posedge clk) chanStatus[0].txEmpty <= 1'b0;
    rd(4'h5, 8'h20, "isr rx b");
    rd(4'h9, 8'h01, "status b");
    chk("irq rx b", {7'h0, irqN}, 8'h00);
    wr(4'h5, 8'h01);
    wt(3);
    chk("irq off", {7'h0, irqN}, 8'h01);
    @(posedge clk) chanStatus[0].breakChange <= 1'b1;
    @(posedge clk) chanStatus[0].breakChange <= 1'b0;
    rd(4'h5, 8'h24, "isr break");
    wr(4'h5, 8'h04);
    wt(3);
    chk("irq break", {7'h0, irqN}, 8'h00);
    wr(4'h2, {CMD_RESET_BREAK, 4'h0});
    wt(3);
    chk("irq cleared", {7'h0, irqN}, 8'h01);
    rd(4'h5, 8'h20, "isr after clear");
    wr(4'h5, 8'h00);
    $display("test interrupt finished");
    @(posedge clk) chanStatus[0].txEmpty <= 1'b1;
    wr(4'hd, 8'h80);
    wt(3);
    chk("oe out", {4'h0, oneOe, twoOe}, 8'h0f);
    chk("pin status", {4'h0, oneOut, twoOut}, 8'h06);
    rd(4'hd, 8'h90, "pins driven");
    wr(4'hd, 8'h00);
    @(posedge clk) begin
      extOne     <= 2'b10;
      extTwo     <= 2'b01;
      extOe      <= 2'b11;
      chanStatus <= '0;
    end
    wt(4);
    chk("oe in", {4'h0, oneOe, twoOe}, 8'h00);
    rd(4'hd, 8'h60, "pins read");
    $display("test pins finished");
    wr(4'h1, {CSR_EXT_16X, CSR_EXT_1X});
    wr(4'h9, {CSR_EXT_1X, CSR_EXT_16X});
    wt(4);
    chk("ext select", {txSel, rxSel, tx16, rx16}, 8'hf9);
    chk("ext clocks", {4'h0, tx_ext_clock, rx_ext_clock}, 8'h09);
    @(posedge clk) begin
      extOne <= 2'b01;
      extTwo <= 2'b10;
    end
    wt(4);
    chk("ext clocks flip", {4'h0, tx_ext_clock, rx_ext_clock}, 8'h06);
    wr(4'h1, 8'h00);
    wt(3);
    chk("ext internal a", {4'h0, txSel, rxSel}, 8'h0a);
    @(posedge clk) extOe <= 2'b00;
    wr(4'hd, 8'h80);
    wt(4);
    chk("ext outputs", {txSel, rxSel, tx_ext_clock, rx_ext_clock}, 8'h00);
    wr(4'hd, 8'h00);
    $display("test external clocks finished");
    @(posedge clk) auxInputOne <= 2'b01;
    wt(6);
    chk("timer clk a", {7'h0, timerClk}, 8'h01);
    rd(4'h5, 8'h80, "isr change");
    rd(4'h4, 8'h22, "change a");
    rd(4'h4, 8'h02, "change cleared");
    @(posedge clk) auxInputOne <= 2'b10;
    wt(6);
    chk("timer clk b", {7'h0, timerClk}, 8'h00);
    rd(4'h4, 8'ha8, "change both");
    @(posedge clk) auxInputOne <= 2'b11;
    wr(4'h4, 8'h20);
    wt(6);
    chk("timer clk off", {7'h0, timerClk}, 8'h00);
    rd(4'hd, 8'hfa, "pins aux");
    rd(4'h4, 8'h2a, "change a rise");
    $display("test aux input finished");
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h03);
    wr(4'h5, 8'h08);
    bus(4'he, 1'b0, 8'h00);
    i = 0;
    while (timerEnd !== 1'b1 && i < 100) begin
      @(posedge clk);
      i++;
    end
    chk("timer end", {7'h0, timerEnd}, 8'h01);
    if (timerEnd !== 1'b1) begin
      give_verdict();
    end
    wt(2);
    chk("irq timer", {7'h0, irqN}, 8'h00);
    rd(4'h5, 8'h08, "isr timer");
    bus(4'hf, 1'b0, 8'h00);
    wt(2);
    chk("timer stop", {7'h0, timerEnd}, 8'h00);
    rd(4'h5, 8'h00, "isr stopped");
    rd(4'h7, 8'h03, "count stopped");
    rd(4'h6, 8'h00, "count upper");
    // External timer clock: only rising edges of channel a's aux input count
    wr(4'h4, 8'h00);
    bus(4'he, 1'b0, 8'h00);
    rd(4'h7, 8'h03, "count held");
    @(posedge clk) auxInputOne <= 2'b01;
    wt(6);
    @(posedge clk) auxInputOne <= 2'b11;
    wt(6);
    rd(4'h7, 8'h03, "count b edge");
    @(posedge clk) auxInputOne <= 2'b10;
    wt(6);
    @(posedge clk) auxInputOne <= 2'b11;
    wt(6);
    rd(4'h7, 8'h02, "count a edge");
    bus(4'hf, 1'b0, 8'h00);
    $display("test timer finished");
    rd(4'h3, 8'h00, "unmapped read");
    wr(4'hc, 8'hff);
    rd(4'hc, 8'h00, "unmapped write");
    $display("test decode finished");
    give_verdict();
  end
endmodule
